// [rtl/dps_pkg.sv]
/*
 * constants, field layouts and carrier types of the dual synthesizer control block.
 * assumes a single pclk domain; serial pins and mode pin are asynchronous to it.
 */
// Function
// - serial data is shifted in on each rising serial clock edge while enable is low, msb first.
// - enable rising edge moves the shifted word into its destination register.
// - short loads select some registers by length alone, without address bits.
// - 8, 16, 24 clocks pick control, reference holding, loop; 32 carries address.
// - serial clock edges never shift while enable is high.
// - two 16-bit holding registers double-buffer reference and secondary loop ratios.
// - a loop register write copies both holding registers into their dividers.
// - external reference mode only when select bit is one and mode pin high.
// - secondary reference ratio is the low sixteen bits of its register.
// - with mode low, auxiliary output divides reference by 8, 10 or 12.5.
// - main loop ratio is the low eighteen bits of the loop register.
// - keep-alive runs during reference standby unless multiplier set inactive.
// - pump mode bits give low only, high only, both, or both floating.
// - control float bit forces both main pumps to float regardless of mode.
// - control float bit forces the secondary detector output to float.
// - adapt timer leaves pumps to the mode bits, then floats high pump and enables low pump.
// - adapt timeout may switch main counters to a second set of ratios.
// - main lock window set by a loop bit; secondary window fixed.
// - lock output ands active loops, follows one if other idles, low if both.
// - converter codes from converter register, zero is low power, reset zero.
// - three-state second output from two bits, one also main loop standby.
// - open-drain third output follows a single secondary reference register bit.
// - first output: 00 static level, 01 main ref, 10 secondary ref, 11 pd pulse.
package dps_pkg;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_HREF = 8'h04;
    localparam logic [7:0] A_LOOP = 8'h08;
    localparam logic [7:0] A_DAC = 8'h0C;
    localparam logic [7:0] A_HSEC = 8'h10;
    localparam logic [7:0] A_SREF = 8'h14;
    localparam logic [7:0] A_AREF = 8'h18;
    localparam logic [7:0] A_ALOOP = 8'h1C;
    localparam logic [7:0] A_STAT = 8'h20;
    localparam logic [7:0] A_DIV = 8'h24;
    // serial address nibble values
    localparam logic [3:0] S_CTRL = 4'h0;
    localparam logic [3:0] S_HREF = 4'h1;
    localparam logic [3:0] S_LOOP = 4'h2;
    localparam logic [3:0] S_DAC = 4'h3;
    localparam logic [3:0] S_HSEC = 4'h4;
    localparam logic [3:0] S_SREF = 4'h5;
    localparam logic [5:0] LEN_CTRL = 6'd8;
    localparam logic [5:0] LEN_HREF = 6'd16;
    localparam logic [5:0] LEN_LOOP = 6'd24;
    localparam logic [5:0] LEN_ADDR = 6'd32;
    // control bits
    localparam int C_LEVEL = 7;
    localparam int C_EXTSEL = 6;
    localparam int C_MFLOAT = 5;
    localparam int C_SFLOAT = 4;
    localparam int C_OUTB = 3;
    localparam int C_REFSB = 2;
    localparam int C_MAINSB = 1;
    localparam int C_SECSB = 0;
    // loop register fields
    localparam int L_MODE = 18;
    localparam int L_TMR = 20;
    localparam int L_WIN = 22;
    localparam int L_ALT = 23;
    // secondary reference fields
    localparam int R_AUX = 16;
    localparam int R_MULT = 18;
    localparam int R_OUTA = 20;
    localparam int R_OUTC = 22;
    localparam logic [1:0] MULT_OFF = 2'b11;
    localparam logic [1:0] PM_LO = 2'b00;
    localparam logic [1:0] PM_HI = 2'b01;
    localparam logic [1:0] PM_BOTH = 2'b10;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [15:0] RST_16 = 16'h0000;
    localparam logic [23:0] RST_24 = 24'h00_0000;
    // adapt timer unit
    localparam int CLK_MHZ = 100;
    localparam int ADAPT_UNIT_NS = 1000;
    localparam logic [11:0] ADAPT_UNIT_CYC = 12'(ADAPT_UNIT_NS * CLK_MHZ / 1000);
    // aux divide ratios, doubled so 12.5 is whole
    localparam logic [4:0] AUX_X2_8 = 5'd16;
    localparam logic [4:0] AUX_X2_10 = 5'd20;
    localparam logic [4:0] AUX_X2_12P5 = 5'd25;
    typedef struct packed {
        logic hi_oe_n;
        logic lo_oe_n;
    } dps_pump_t;
    typedef struct packed {
        logic sclk;
        logic sdin;
        logic enb_n;
        logic mode;
    } dps_pins_t;
endpackage

// [rtl/dps_serial_control.sv]
/*
 * dual synthesizer control: three-wire serial loader, apb register slave,
 * double-buffered dividers, pump/adapt control, lock combine, general outputs.
 * assumes serial pins and mode pin are asynchronous; counters and lock
 * detectors outside supply pulses and lock levels on pclk.
 */
// Chosen here: the register addresses and the APB slave port.
module dps_serial_control (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire dps_pkg::dps_pins_t pins,
    input wire logic main_ref_pulse,
    input wire logic sec_ref_pulse,
    input wire logic pd_pulse,
    input wire logic main_lock,
    input wire logic second_lock,
    output logic [15:0] main_ref_ratio,
    output logic [17:0] main_loop_ratio,
    output logic [15:0] second_ref_ratio,
    output logic [15:0] second_loop_ratio,
    output logic external_reference_mode,
    output logic aux_active,
    output logic [4:0] aux_ratio_x2,
    output logic keepalive_en,
    output logic main_window_sel,
    output dps_pkg::dps_pump_t pump,
    output logic second_detector_float,
    output logic lock_indicate,
    output logic [7:0] converter_out_one,
    output logic [7:0] converter_out_two,
    output logic converter_one_lowpwr,
    output logic converter_two_lowpwr,
    output logic out_a,
    output logic out_b,
    output logic out_b_oe_n,
    output logic out_c_oe_n
);
    dps_pkg::dps_pins_t meta_r;
    dps_pkg::dps_pins_t sync_r;
    logic sclk_d_r;
    logic enb_d_r;
    logic [31:0] shift_r;
    logic [5:0] count_r;
    logic [7:0] ctrl_r;
    logic [15:0] main_ref_holding_r;
    logic [23:0] loop_r;
    logic [15:0] dac_r;
    logic [15:0] second_loop_holding_r;
    logic [23:0] sref_r;
    logic [15:0] alt_ref_r;
    logic [17:0] alt_loop_r;
    logic [15:0] ref_div_r;
    logic [15:0] sec_div_r;
    logic [11:0] unit_r;
    logic [1:0] tmr_r;
    logic adapt_run_r;
    logic adapt_done_r;
    logic [31:0] rdata_nxt;
    logic sclk_rise;
    logic enb_rise;
    logic s_load;
    logic s_ctrl;
    logic s_href;
    logic s_loop;
    logic s_dac;
    logic s_hsec;
    logic s_sref;
    logic [23:0] s_data;
    logic a_wr;
    logic a_map;
    logic loop_wr;
    logic main_sb;
    logic sec_sb;
    logic hi_on;
    logic lo_on;

    // two flops on every pin before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // idle enable high, so no false release edge after reset
            meta_r <= '{sclk: 1'b0, sdin: 1'b0, enb_n: 1'b1, mode: 1'b0};
            sync_r <= '{sclk: 1'b0, sdin: 1'b0, enb_n: 1'b1, mode: 1'b0};
        end else if (ce) begin
            meta_r <= pins;
            sync_r <= meta_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_d_r <= 1'b0;
            enb_d_r <= 1'b1;
        end else if (ce) begin
            sclk_d_r <= sync_r.sclk;
            enb_d_r <= sync_r.enb_n;
        end
    end

    assign sclk_rise = sync_r.sclk & ~sclk_d_r;
    assign enb_rise = sync_r.enb_n & ~enb_d_r;

    // count saturates so overlong bursts never alias to a short load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_r <= 32'h0000_0000;
            count_r <= 6'd0;
        end else if (ce) begin
            if (sync_r.enb_n) begin
                if (!sync_r.sclk) begin
                    count_r <= 6'd0;
                end
            end else if (sclk_rise) begin
                shift_r <= {shift_r[30:0], sync_r.sdin};
                if (count_r != 6'd63) begin
                    count_r <= count_r + 6'd1;
                end
            end
        end
    end

    // destination decode at enable release
    assign s_load = enb_rise;
    assign s_data = (count_r == dps_pkg::LEN_ADDR) ? shift_r[23:0] : shift_r[23:0];
    always_comb begin
        s_ctrl = 1'b0;
        s_href = 1'b0;
        s_loop = 1'b0;
        s_dac = 1'b0;
        s_hsec = 1'b0;
        s_sref = 1'b0;
        if (s_load) begin
            case (count_r)
                dps_pkg::LEN_CTRL: s_ctrl = 1'b1;
                dps_pkg::LEN_HREF: s_href = 1'b1;
                dps_pkg::LEN_LOOP: s_loop = 1'b1;
                dps_pkg::LEN_ADDR: begin
                    s_ctrl = shift_r[31:28] == dps_pkg::S_CTRL;
                    s_href = shift_r[31:28] == dps_pkg::S_HREF;
                    s_loop = shift_r[31:28] == dps_pkg::S_LOOP;
                    s_dac = shift_r[31:28] == dps_pkg::S_DAC;
                    s_hsec = shift_r[31:28] == dps_pkg::S_HSEC;
                    s_sref = shift_r[31:28] == dps_pkg::S_SREF;
                end
                default: ;
            endcase
        end
    end

    // apb: zero wait while ce is high, error on unmapped
    assign a_wr = psel & penable & pwrite & ce;
    assign pready = ce;
    always_comb begin
        a_map = 1'b1;
        rdata_nxt = 32'h0000_0000;
        case (paddr)
            dps_pkg::A_CTRL: rdata_nxt = {24'h00_0000, ctrl_r};
            dps_pkg::A_HREF: rdata_nxt = {16'h0000, main_ref_holding_r};
            dps_pkg::A_LOOP: rdata_nxt = {8'h00, loop_r};
            dps_pkg::A_DAC: rdata_nxt = {16'h0000, dac_r};
            dps_pkg::A_HSEC: rdata_nxt = {16'h0000, second_loop_holding_r};
            dps_pkg::A_SREF: rdata_nxt = {8'h00, sref_r};
            dps_pkg::A_AREF: rdata_nxt = {16'h0000, alt_ref_r};
            dps_pkg::A_ALOOP: rdata_nxt = {14'h0000, alt_loop_r};
            dps_pkg::A_STAT: rdata_nxt = {26'h000_0000, count_r == 6'd0, external_reference_mode,
                                           lock_indicate, adapt_done_r, adapt_run_r, sync_r.mode};
            dps_pkg::A_DIV: rdata_nxt = {sec_div_r, ref_div_r};
            default: a_map = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & ~a_map;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (ce && psel && !penable && !pwrite) begin
            prdata <= rdata_nxt;
        end
    end

    // serial load wins over an apb write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= dps_pkg::RST_CTRL;
            main_ref_holding_r <= dps_pkg::RST_16;
            loop_r <= dps_pkg::RST_24;
            dac_r <= dps_pkg::RST_16;
            second_loop_holding_r <= dps_pkg::RST_16;
            sref_r <= dps_pkg::RST_24;
            alt_ref_r <= dps_pkg::RST_16;
            alt_loop_r <= 18'h0_0000;
        end else if (ce) begin
            if (s_ctrl) ctrl_r <= s_data[7:0];
            else if (a_wr && paddr == dps_pkg::A_CTRL) ctrl_r <= pwdata[7:0];
            if (s_href) main_ref_holding_r <= s_data[15:0];
            else if (a_wr && paddr == dps_pkg::A_HREF) main_ref_holding_r <= pwdata[15:0];
            if (s_loop) loop_r <= s_data;
            else if (a_wr && paddr == dps_pkg::A_LOOP) loop_r <= pwdata[23:0];
            if (s_dac) dac_r <= s_data[15:0];
            else if (a_wr && paddr == dps_pkg::A_DAC) dac_r <= pwdata[15:0];
            if (s_hsec) second_loop_holding_r <= s_data[15:0];
            else if (a_wr && paddr == dps_pkg::A_HSEC) second_loop_holding_r <= pwdata[15:0];
            if (s_sref) sref_r <= s_data;
            else if (a_wr && paddr == dps_pkg::A_SREF) sref_r <= pwdata[23:0];
            if (a_wr && paddr == dps_pkg::A_AREF) alt_ref_r <= pwdata[15:0];
            if (a_wr && paddr == dps_pkg::A_ALOOP) alt_loop_r <= pwdata[17:0];
        end
    end

    assign loop_wr = s_loop | (a_wr & ~s_loop & (paddr == dps_pkg::A_LOOP));

    // holding registers only reach the counters on a loop write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_div_r <= dps_pkg::RST_16;
            sec_div_r <= dps_pkg::RST_16;
        end else if (ce && loop_wr) begin
            ref_div_r <= main_ref_holding_r;
            sec_div_r <= second_loop_holding_r;
        end
    end

    // adapt timer: code times unit, restarted by every loop write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_r <= 12'd0;
            tmr_r <= 2'd0;
            adapt_run_r <= 1'b0;
            adapt_done_r <= 1'b0;
        end else if (ce) begin
            if (loop_wr) begin
                adapt_done_r <= 1'b0;
                adapt_run_r <= 1'b0;
                unit_r <= 12'd0;
                tmr_r <= 2'd0;
            end else if (!adapt_run_r && !adapt_done_r && loop_r[dps_pkg::L_TMR +: 2] != 2'b00) begin
                adapt_run_r <= 1'b1;
                tmr_r <= loop_r[dps_pkg::L_TMR +: 2];
                unit_r <= dps_pkg::ADAPT_UNIT_CYC - 12'd1;
            end else if (adapt_run_r) begin
                if (unit_r != 12'd0) begin
                    unit_r <= unit_r - 12'd1;
                end else if (tmr_r == 2'd1) begin
                    adapt_run_r <= 1'b0;
                    adapt_done_r <= 1'b1;
                end else begin
                    tmr_r <= tmr_r - 2'd1;
                    unit_r <= dps_pkg::ADAPT_UNIT_CYC - 12'd1;
                end
            end
        end
    end

    // second ratio set engaged only after timeout
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_ref_ratio <= dps_pkg::RST_16;
            main_loop_ratio <= 18'h0_0000;
            second_ref_ratio <= dps_pkg::RST_16;
            second_loop_ratio <= dps_pkg::RST_16;
        end else if (ce) begin
            if (adapt_done_r && loop_r[dps_pkg::L_ALT]) begin
                main_ref_ratio <= alt_ref_r;
                main_loop_ratio <= alt_loop_r;
            end else begin
                main_ref_ratio <= ref_div_r;
                main_loop_ratio <= loop_r[17:0];
            end
            second_ref_ratio <= sref_r[15:0];
            second_loop_ratio <= sec_div_r;
        end
    end

    assign main_sb = ctrl_r[dps_pkg::C_MAINSB];
    assign sec_sb = ctrl_r[dps_pkg::C_SECSB];

    // pump enables; timeout overrides the programmed mode
    always_comb begin
        case (loop_r[dps_pkg::L_MODE +: 2])
            dps_pkg::PM_LO: {hi_on, lo_on} = 2'b01;
            dps_pkg::PM_HI: {hi_on, lo_on} = 2'b10;
            dps_pkg::PM_BOTH: {hi_on, lo_on} = 2'b11;
            default: {hi_on, lo_on} = 2'b00;
        endcase
        if (adapt_done_r) begin
            {hi_on, lo_on} = 2'b01;
        end
    end

    // mode pin gates ext reference and aux output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pump <= '1;
            second_detector_float <= 1'b1;
            external_reference_mode <= 1'b0;
            aux_active <= 1'b0;
            aux_ratio_x2 <= dps_pkg::AUX_X2_8;
            keepalive_en <= 1'b0;
            main_window_sel <= 1'b0;
            lock_indicate <= 1'b0;
        end else if (ce) begin
            pump.hi_oe_n <= ~hi_on | ctrl_r[dps_pkg::C_MFLOAT] | main_sb;
            pump.lo_oe_n <= ~lo_on | ctrl_r[dps_pkg::C_MFLOAT] | main_sb;
            second_detector_float <= ctrl_r[dps_pkg::C_SFLOAT] | sec_sb;
            external_reference_mode <= ctrl_r[dps_pkg::C_EXTSEL] & sync_r.mode;
            // ratio divisibility while aux runs is left to software
            aux_active <= ~sync_r.mode & (sref_r[dps_pkg::R_AUX +: 2] != 2'b00);
            case (sref_r[dps_pkg::R_AUX +: 2])
                2'b10: aux_ratio_x2 <= dps_pkg::AUX_X2_10;
                2'b11: aux_ratio_x2 <= dps_pkg::AUX_X2_12P5;
                default: aux_ratio_x2 <= dps_pkg::AUX_X2_8;
            endcase
            keepalive_en <= ctrl_r[dps_pkg::C_REFSB] &
                            (sref_r[dps_pkg::R_MULT +: 2] != dps_pkg::MULT_OFF);
            main_window_sel <= loop_r[dps_pkg::L_WIN];
            case ({main_sb, sec_sb})
                2'b00: lock_indicate <= main_lock & second_lock;
                2'b01: lock_indicate <= main_lock;
                2'b10: lock_indicate <= second_lock;
                default: lock_indicate <= 1'b0;
            endcase
        end
    end

    // general outputs; b drives only while its enable bit is set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_a <= 1'b0;
            out_b <= 1'b0;
            out_b_oe_n <= 1'b1;
            out_c_oe_n <= 1'b1;
            converter_out_one <= 8'h00;
            converter_out_two <= 8'h00;
            converter_one_lowpwr <= 1'b1;
            converter_two_lowpwr <= 1'b1;
        end else if (ce) begin
            case (sref_r[dps_pkg::R_OUTA +: 2])
                2'b00: out_a <= ctrl_r[dps_pkg::C_LEVEL];
                2'b01: out_a <= main_ref_pulse;
                2'b10: out_a <= sec_ref_pulse;
                default: out_a <= pd_pulse;
            endcase
            out_b <= main_sb;
            out_b_oe_n <= ~ctrl_r[dps_pkg::C_OUTB];
            out_c_oe_n <= ~sref_r[dps_pkg::R_OUTC];
            converter_out_one <= dac_r[7:0];
            converter_out_two <= dac_r[15:8];
            converter_one_lowpwr <= dac_r[7:0] == 8'h00;
            converter_two_lowpwr <= dac_r[15:8] == 8'h00;
        end
    end
endmodule

// [test/dps_serial_control_asserts.sv]
/* port checker of the serial control block.
   assumes a bind to the top module; pclk domain only. */
module dps_serial_control_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire dps_pkg::dps_pins_t pins,
    input wire logic main_lock,
    input wire logic second_lock,
    input wire logic external_reference_mode,
    input wire logic aux_active,
    input wire logic [4:0] aux_ratio_x2,
    input wire dps_pkg::dps_pump_t pump,
    input wire logic lock_indicate,
    input wire logic [7:0] converter_out_one,
    input wire logic [7:0] converter_out_two,
    input wire logic converter_one_lowpwr,
    input wire logic converter_two_lowpwr,
    input wire logic out_b
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // mode pin passes a two-stage sync, so five cycles of margin
    a_ext_needs_mode: assert property (!pins.mode [*5] |-> !external_reference_mode)
        else $error("external mode with mode pin low");
    a_aux_mode_low: assert property (pins.mode [*5] |-> !aux_active)
        else $error("aux output with mode pin high");
    a_aux_ratio_set: assert property (aux_ratio_x2 inside {5'h10, 5'h14, 5'h19})
        else $error("aux ratio outside the three choices");
    a_lock_both_low: assert property ((!main_lock && !second_lock) [*3] |-> !lock_indicate)
        else $error("lock shown with no loop locked");
    a_conv_one_low: assert property ($stable(converter_out_one) |-> converter_one_lowpwr == (converter_out_one == 8'h00))
        else $error("converter one low power mismatch");
    a_conv_two_low: assert property ($stable(converter_out_two) |-> converter_two_lowpwr == (converter_out_two == 8'h00))
        else $error("converter two low power mismatch");
    a_standby_floats: assert property ($stable(out_b) && out_b |-> pump == 2'b11)
        else $error("pumps driving during main standby");
    a_reset_low_power: assert property ($rose(presetn) |-> converter_one_lowpwr && converter_two_lowpwr)
        else $error("converters not low power after reset");
endmodule

bind dps_serial_control dps_serial_control_asserts chk_u (.pclk, .presetn, .pins, .main_lock, .second_lock,
    .external_reference_mode, .aux_active, .aux_ratio_x2, .pump, .lock_indicate, .converter_out_one,
    .converter_out_two, .converter_one_lowpwr, .converter_two_lowpwr, .out_b);

// [test/dps_serial_master.sv]
/* behavioural three-wire serial master.
   assumes the bench calls send and stray; stray clocks the link outside frames. */
module dps_serial_master (
    output logic sclk,
    output logic sdin,
    output logic enb_n
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sclk = 1'b0;
        sdin = 1'b0;
        enb_n = 1'b1;
    end
    task automatic send(input logic [31:0] word, input int n);
        enb_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            sdin = word[i];
            #62.5 sclk = 1'b1;
            #62.5 sclk = 1'b0;
        end
        #62.5 enb_n = 1'b1;
        // no hold after the frame: data line flips
        sdin = ~sdin;
        #250;
    endtask
    task automatic stray(input int n);
        repeat (n) begin
            sdin = ~sdin;
            #62.5 sclk = 1'b1;
            #62.5 sclk = 1'b0;
        end
    endtask
endmodule

// [test/dps_serial_control_bench.sv]
/* self-checking bench: register model compared with every output.
   assumes the serial master model and the bound checker. */
module dps_serial_control_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk, presetn, psel, penable, pwrite, mode, ml, sl, p0, p1, p2, sc, sd, en, er, ce;
    logic pready, pslverr, xm, aa, ka, ws, sdf, li, l1, l2, oa, ob, obe, oce;
    logic [7:0] paddr, c1, c2;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] mrr, srr, slr;
    logic [17:0] mlr;
    logic [4:0] ax;
    dps_pkg::dps_pump_t pu;
    dps_pkg::dps_pins_t pins;
    int sh[8];
    int msk[8] = '{32'hff, 32'hffff, 32'h00ff_ffff, 32'hffff, 32'hffff, 32'h00ff_ffff, 32'hffff, 32'h0003_ffff};
    logic [4:0] axt[4] = '{5'h10, dps_pkg::AUX_X2_8, dps_pkg::AUX_X2_10, dps_pkg::AUX_X2_12P5};
    int rref, sloop, adone, bad_count, checks;
    assign pins = {sc, sd, en, mode};
    dps_serial_master ser_u (.sclk(sc), .sdin(sd), .enb_n(en));
    dps_serial_control dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pins(pins), .main_ref_pulse(p0), .sec_ref_pulse(p1), .pd_pulse(p2), .main_lock(ml), .second_lock(sl),
        .main_ref_ratio(mrr), .main_loop_ratio(mlr), .second_ref_ratio(srr), .second_loop_ratio(slr),
        .external_reference_mode(xm), .aux_active(aa), .aux_ratio_x2(ax), .keepalive_en(ka),
        .main_window_sel(ws), .pump(pu), .second_detector_float(sdf), .lock_indicate(li),
        .converter_out_one(c1), .converter_out_two(c2), .converter_one_lowpwr(l1), .converter_two_lowpwr(l2),
        .out_a(oa), .out_b(ob), .out_b_oe_n(obe), .out_c_oe_n(oce));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("bad_count=%0d checks=%0d", bad_count, checks);
        if (bad_count == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    function automatic void put(input int i, input int d);
        sh[i] = d & msk[i];
        // loop write moves both holding values into the dividers
        if (i == 2) begin
            rref = sh[1];
            sloop = sh[4];
            adone = 0;
        end
    endfunction
    task automatic apb(input logic w, input int a, input int d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= 8'(a);
        pwdata <= 32'(d);
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        if (n == 50) begin
            bad_count++;
            finish_test;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (w && a < 32) put(a / 4, d);
    endtask
    task automatic ser(input int w, input int n, input int i);
        ser_u.send(w, n);
        if (i >= 0) put(i, w);
    endtask
    task automatic rdall;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, i * 4, 0);
            chk(rd, sh[i]);
        end
        apb(1'b0, 32'h24, 0);
        chk(rd, {sloop[15:0], rref[15:0]});
        // serial idle, no adapt, mode pin low, no lock
        apb(1'b0, 32'h20, 0);
        chk(rd, 32'h0000_0020);
    endtask
    task automatic check_all;
        int c, pm, s, a, alt;
        repeat (6) @(posedge pclk);
        c = sh[0];
        pm = (sh[2] >> 18) & 3;
        s = (sh[5] >> 20) & 3;
        a = (sh[5] >> 16) & 3;
        alt = adone && sh[2][23];
        chk(mrr, alt ? sh[6] : rref);
        chk(mlr, alt ? sh[7] : sh[2] & 32'h0003_ffff);
        chk(slr, sloop);
        chk(srr, sh[5] & 32'hffff);
        chk(xm, c[6] & mode);
        chk(aa, !mode && a != 0);
        chk(ax, axt[a]);
        chk(ka, c[2] && ((sh[5] >> 18) & 3) != 3);
        chk(ws, sh[2][22]);
        chk(pu, c[5] | c[1] | pm == 3 ? 2'b11 : adone ? 2'b10 : pm == 1 ? 2'b01 : pm == 2 ? 2'b00 : 2'b10);
        chk(sdf, c[4] | c[0]);
        chk(li, c[1] && c[0] ? 0 : c[1] ? sl : c[0] ? ml : ml & sl);
        chk(c1, sh[3] & 32'hff);
        chk(c2, sh[3] >> 8);
        chk(l1, (sh[3] & 32'hff) == 0);
        chk(l2, (sh[3] >> 8) == 0);
        chk(oa, s == 0 ? c[7] : s == 1 ? p0 : s == 2 ? p1 : p2);
        chk(ob, c[1]);
        chk(obe, !c[3]);
        chk(oce, !sh[5][22]);
    endtask
    initial begin
        {psel, penable, pwrite, mode, ml, sl, p0, p1, p2} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ce = 1'b1;
        presetn = 1'b0;
        void'($urandom(95));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        check_all;
        rdall;
        apb(1'b0, 32'h28, 0);
        chk(er, 1'b1);
        for (int k = 0; k < 2; k++) begin
            ser_u.stray(3);
            ser($urandom, 8, 0);
            ser($urandom, 16, 1);
            ser(32'h4000_0000 | ($urandom & 32'h0fff_ffff), 32, 4);
            check_all;
            ser($urandom & 32'hffcf_ffff, 24, 2);
            ser(32'h3000_0000 | ($urandom & 32'h0fff_ffff), 32, 3);
            // ratio kept even while aux may run
            ser(32'h5000_0000 | ($urandom & 32'h0fff_fffe), 32, 5);
            ser($urandom, 12, -1);
            ser(32'h6000_0000 | $urandom, 32, -1);
            check_all;
            rdall;
        end
        for (int k = 0; k < 16; k++) begin
            {ml, sl} <= k[3:2];
            {p0, p1, p2} <= 3'($urandom);
            mode <= k[1];
            apb(1'b1, 0, (k & 3) | 32'h40 | ($urandom & 32'h9c));
            apb(1'b1, 8, ((k >> 2) << 18) | ($urandom & 32'h00c3_ffff));
            apb(1'b1, 32'h14, ((k >> 2) << 20) | ($urandom & 32'h00cf_fffe));
            apb(1'b1, 32'h18, $urandom);
            apb(1'b1, 32'h1c, $urandom);
            check_all;
        end
        // frozen clock enable stretches the access phase
        ce <= 1'b0;
        fork
            apb(1'b1, 32'h18, 32'h0000_1234);
            begin
                repeat (4) @(posedge pclk);
                ce <= 1'b1;
            end
        join
        apb(1'b1, 0, 0);
        apb(1'b1, 8, 32'h0094_0000 | ($urandom & 32'h0003_ffff));
        check_all;
        repeat (110) @(posedge pclk);
        adone = 1;
        check_all;
        finish_test;
    end
    initial begin
        #300us;
        bad_count++;
        finish_test;
    end
endmodule
